// [src/fpi_defines.svh]
`ifndef FPI_DEFINES_SVH
`define FPI_DEFINES_SVH

// register byte offsets
`define FPI_OFS_CTRL 8'h00
`define FPI_OFS_STATUS 8'h04
`define FPI_OFS_TAG 8'h08
`define FPI_OFS_CMD 8'h0c
`define FPI_OFS_EXC 8'h10
`define FPI_OFS_OPCODE 8'h14
`define FPI_OFS_IPTR 8'h18
`define FPI_OFS_OPTR 8'h1c
`define FPI_OFS_IRQ_STAT 8'h20
`define FPI_OFS_IRQ_CLR 8'h24
`define FPI_OFS_IRQ_EN 8'h28
// data registers live at 0x40..0x5c, selected by address bits 7:5
`define FPI_DATA_SEL 3'h2
`define FPI_DATA_REGS 8

// reset and initialize values
`define FPI_MASK_ALL 6'h3f
`define FPI_MASK_RESET 6'h3e
`define FPI_RC_NEAREST 2'h0
`define FPI_PC_EXT 2'h3
`define FPI_TAG_EMPTY 16'hffff
`define FPI_TOP_ZERO 3'h0
`define FPI_CC_CLEAR 4'h0
`define FPI_FLAGS_CLEAR 6'h00
`define FPI_FLAGS_RESET 6'h01
`define FPI_IRQ_NONE 3'h0

// field positions
`define FPI_INVALID_BIT 0
`define FPI_CW_IC_BIT 12
`define FPI_SW_BUSY_BIT 15
`define FPI_CMD_INIT_BIT 0
`define FPI_CMD_CLEAR_BIT 1
`define FPI_EXC_SF_BIT 6
`define FPI_IRQ_MASKED_BIT 0
`define FPI_IRQ_ERROR_BIT 1
`define FPI_IRQ_INIT_BIT 2

`endif

// [src/fpi_pkg.sv]
package fpi_pkg;
  typedef logic [5:0] fpi_exc_type;
  typedef logic [2:0] fpi_idx_type;
  typedef logic [31:0] fpi_word_type;

  // keep only the flag of highest precedence: lower bit index wins
  function automatic fpi_exc_type fpi_pick_type_fn(input fpi_exc_type det);
    fpi_exc_type one;
    one = '0;
    for (int i = 5; i >= 0; i--) begin
      if (det[i]) begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction
endpackage

// [src/fpi_link_if.sv]
interface fpi_link_if;
  import fpi_pkg::*;
  logic det_valid;
  fpi_exc_type det;
  fpi_exc_type masks;
  fpi_exc_type pick;
  logic unmasked;
  logic mem_wr;
  fpi_idx_type mem_wr_idx;
  fpi_word_type mem_wr_data;
  fpi_idx_type mem_rd_idx;
  fpi_word_type mem_rd_data;

  modport core_mp(output det_valid, det, masks, mem_wr, mem_wr_idx, mem_wr_data, mem_rd_idx,
                  input pick, unmasked, mem_rd_data);
  modport exc_mp(input det_valid, det, masks, output pick, unmasked);
  modport mem_mp(input mem_wr, mem_wr_idx, mem_wr_data, mem_rd_idx, output mem_rd_data);
endinterface

// [src/fpi_exc_unit.sv]
`include "fpi_defines.svh"

module fpi_exc_unit
  import fpi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  fpi_link_if.exc_mp lnk
);
  // only one exception is reported when several arrive together
  always_comb begin
    lnk.pick = fpi_pick_type_fn(lnk.det);
    lnk.unmasked = |(lnk.pick & ~lnk.masks);
  end

  property p_invalid_wins;
    @(posedge clk_sys) disable iff (!rstn)
    (lnk.det_valid && lnk.det[`FPI_INVALID_BIT]) |-> (lnk.pick == 6'h01);
  endproperty
  a_invalid_wins: assert property (p_invalid_wins) else $error("invalid did not take precedence");

  property p_single_pick;
    @(posedge clk_sys) disable iff (!rstn)
    lnk.det_valid |-> ($onehot(lnk.pick) == (lnk.det != 6'h00)) && ((lnk.pick & ~lnk.det) == 6'h00);
  endproperty
  a_single_pick: assert property (p_single_pick) else $error("more than one exception reported");
endmodule

// [src/fpi_data_mem.sv]
`include "fpi_defines.svh"

module fpi_data_mem
  import fpi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  fpi_link_if.mem_mp lnk
);
  fpi_word_type mem [0:`FPI_DATA_REGS-1];

  // array has no reset; contents survive initialize
  always_ff @(posedge clk_sys) begin
    if (lnk.mem_wr) begin
      mem[lnk.mem_wr_idx] <= lnk.mem_wr_data;
    end
  end

  // registered read port, taken in the bus address phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lnk.mem_rd_data <= 32'h0;
    end else begin
      lnk.mem_rd_data <= mem[lnk.mem_rd_idx];
    end
  end
endmodule

// [src/fpi_top.sv]
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`include "fpi_defines.svh"

module fpi_top
  import fpi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic error_n,
  output logic irq
);
  fpi_link_if lnk();

  // address decode of the data register window
  function automatic logic is_data(input logic [7:0] addr);
    return addr[7:5] == `FPI_DATA_SEL;
  endfunction

  logic addr_ok;
  logic dph_valid;
  logic dph_write;
  logic dph_data;
  logic [7:0] dph_addr;
  logic wr;
  logic wr_ctrl;
  logic wr_tag;
  logic wr_cmd;
  logic wr_exc;
  logic init_cmd;
  logic clr_cmd;
  fpi_exc_type masks;
  logic [1:0] rc;
  logic [1:0] pc;
  fpi_exc_type flags;
  logic sf;
  logic es;
  logic [3:0] cc;
  logic [2:0] top;
  logic [15:0] tags;
  logic [31:0] opcode;
  logic [31:0] iptr;
  logic [31:0] optr;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [2:0] irq_ev;
  logic [15:0] ctrl_word;
  logic [15:0] status_word;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;
  logic after_reset_seen;

  fpi_exc_unit u_exc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .lnk(lnk.exc_mp)
  );

  fpi_data_mem u_mem (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .lnk(lnk.mem_mp)
  );

  // bus answers in zero wait states, always OKAY; only word transfers are expected
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1];

  // address phase capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_data <= 1'b0;
      dph_addr <= 8'h00;
    end else begin
      dph_valid <= addr_ok;
      dph_write <= hwrite;
      dph_data <= is_data(haddr[7:0]);
      dph_addr <= haddr[7:0];
    end
  end

  // write strobes in the data phase
  assign wr = dph_valid && dph_write;
  assign wr_ctrl = wr && (dph_addr == `FPI_OFS_CTRL);
  assign wr_tag = wr && (dph_addr == `FPI_OFS_TAG);
  assign wr_cmd = wr && (dph_addr == `FPI_OFS_CMD);
  assign wr_exc = wr && (dph_addr == `FPI_OFS_EXC);
  assign init_cmd = wr_cmd && hwdata[`FPI_CMD_INIT_BIT];
  assign clr_cmd = wr_cmd && hwdata[`FPI_CMD_CLEAR_BIT];

  // links to the exception unit and the data register memory
  assign lnk.det_valid = wr_exc;
  assign lnk.det = hwdata[5:0];
  assign lnk.masks = masks;
  assign lnk.mem_wr = wr && dph_data && !init_cmd;
  assign lnk.mem_wr_idx = dph_addr[4:2];
  assign lnk.mem_wr_data = hwdata;
  assign lnk.mem_rd_idx = haddr[4:2];

  // control word: reset differs from initialize only in the invalid mask
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      masks <= `FPI_MASK_RESET;
      rc <= `FPI_RC_NEAREST;
      pc <= `FPI_PC_EXT;
    end else if (init_cmd) begin
      masks <= `FPI_MASK_ALL;
      rc <= `FPI_RC_NEAREST;
      pc <= `FPI_PC_EXT;
    end else if (wr_ctrl) begin
      masks <= hwdata[5:0];
      pc <= hwdata[9:8];
      rc <= hwdata[11:10];
    end
  end

  // status word; an exception in the same cycle as a clear keeps its flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags <= `FPI_FLAGS_RESET;
      es <= 1'b1;
      sf <= 1'b0;
      cc <= `FPI_CC_CLEAR;
      top <= `FPI_TOP_ZERO;
    end else if (init_cmd) begin
      flags <= `FPI_FLAGS_CLEAR;
      es <= 1'b0;
      sf <= 1'b0;
      cc <= `FPI_CC_CLEAR;
      top <= `FPI_TOP_ZERO;
    end else if (lnk.det_valid) begin
      flags <= flags | lnk.pick;
      cc <= hwdata[11:8];
      if (hwdata[`FPI_EXC_SF_BIT]) begin
        sf <= 1'b1;
      end
      if (lnk.unmasked) begin
        es <= 1'b1;
      end
    end else if (clr_cmd) begin
      flags <= `FPI_FLAGS_CLEAR;
      es <= 1'b0;
      sf <= 1'b0;
    end
  end

  // tag word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tags <= `FPI_TAG_EMPTY;
    end else if (init_cmd) begin
      tags <= `FPI_TAG_EMPTY;
    end else if (wr_tag) begin
      tags <= hwdata[15:0];
    end
  end

  // saved exception pointers: software loads them, initialize leaves them alone
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      opcode <= 32'h0;
      iptr <= 32'h0;
      optr <= 32'h0;
    end else if (wr && !init_cmd) begin
      if (dph_addr == `FPI_OFS_OPCODE) begin
        opcode <= {21'h0, hwdata[10:0]};
      end
      if (dph_addr == `FPI_OFS_IPTR) begin
        iptr <= hwdata;
      end
      if (dph_addr == `FPI_OFS_OPTR) begin
        optr <= hwdata;
      end
    end
  end

  // error line is the inverted summary bit, a flop, so it cannot glitch
  assign error_n = ~es;

  // interrupt events: masked fix-up, unmasked error, initialize done
  always_comb begin
    irq_ev = `FPI_IRQ_NONE;
    irq_ev[`FPI_IRQ_MASKED_BIT] = lnk.det_valid && !lnk.unmasked && (lnk.det != 6'h00);
    irq_ev[`FPI_IRQ_ERROR_BIT] = lnk.det_valid && lnk.unmasked;
    irq_ev[`FPI_IRQ_INIT_BIT] = init_cmd;
  end

  // sticky status: a new event beats a clear written in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= `FPI_IRQ_NONE;
    end else if (wr && (dph_addr == `FPI_OFS_IRQ_CLR)) begin
      irq_stat <= (irq_stat & ~hwdata[2:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_en <= `FPI_IRQ_NONE;
    end else if (wr && (dph_addr == `FPI_OFS_IRQ_EN)) begin
      irq_en <= hwdata[2:0];
    end
  end

  // registered level, one cycle behind the status bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // word images; the old infinity-control position is hard zero
  assign ctrl_word = {3'h0, 1'b0, rc, pc, 2'h0, masks};
  assign status_word = {es, cc[3], top, cc[2:0], es, sf, flags};

  // read mux, sampled in the address phase so hrdata leaves a flop
  always_comb begin
    next_rdata = 32'h0;
    case (haddr[7:0])
      `FPI_OFS_CTRL: next_rdata = {16'h0, ctrl_word};
      `FPI_OFS_STATUS: next_rdata = {16'h0, status_word};
      `FPI_OFS_TAG: next_rdata = {16'h0, tags};
      `FPI_OFS_OPCODE: next_rdata = opcode;
      `FPI_OFS_IPTR: next_rdata = iptr;
      `FPI_OFS_OPTR: next_rdata = optr;
      `FPI_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      `FPI_OFS_IRQ_EN: next_rdata = {29'h0, irq_en};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      rdata_q <= next_rdata;
    end
  end

  assign hrdata = dph_data ? lnk.mem_rd_data : rdata_q;

  // helper marking the first edge after reset release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      after_reset_seen <= 1'b0;
    end else begin
      after_reset_seen <= 1'b1;
    end
  end

  property p_init_masks;
    @(posedge clk_sys) disable iff (!rstn)
    init_cmd |=> (masks == 6'h3f) && (ctrl_word[5:0] == 6'h3f);
  endproperty
  a_init_masks: assert property (p_init_masks) else $error("masks not all set after initialize");

  property p_init_round;
    @(posedge clk_sys) disable iff (!rstn)
    init_cmd |=> (ctrl_word[11:10] == 2'h0) && (ctrl_word[9:8] == 2'h3);
  endproperty
  a_init_round: assert property (p_init_round) else $error("rounding or precision wrong after initialize");

  property p_init_tags;
    @(posedge clk_sys) disable iff (!rstn)
    init_cmd |=> (tags == 16'hffff) && (status_word[13:11] == 3'h0);
  endproperty
  a_init_tags: assert property (p_init_tags) else $error("tags or stack top wrong after initialize");

  property p_init_status;
    @(posedge clk_sys) disable iff (!rstn)
    init_cmd |=> (status_word == 16'h0000) ##1 ((status_word[7] == 1'b0) || $past(lnk.det_valid && lnk.unmasked));
  endproperty
  a_init_status: assert property (p_init_status) else $error("status word not clear after initialize");

  property p_init_keeps;
    @(posedge clk_sys) disable iff (!rstn)
    init_cmd |=> $stable(opcode) && $stable(iptr) && $stable(optr);
  endproperty
  a_init_keeps: assert property (p_init_keeps) else $error("initialize changed saved pointers");

  property p_no_infinity;
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctrl && hwdata[`FPI_CW_IC_BIT]) |=> (ctrl_word[`FPI_CW_IC_BIT] == 1'b0);
  endproperty
  a_no_infinity: assert property (p_no_infinity) else $error("infinity control bit stored");

  property p_reset_state;
    @(posedge clk_sys) disable iff (!rstn)
    !after_reset_seen |-> (masks[0] == 1'b0) && flags[0] && es && status_word[`FPI_SW_BUSY_BIT] && !error_n;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state differs from expected");

  property p_error_until_init;
    @(posedge clk_sys) disable iff (!rstn)
    (!error_n && init_cmd) |=> error_n;
  endproperty
  a_error_until_init: assert property (p_error_until_init) else $error("initialize left error line low");

  property p_error_follows;
    @(posedge clk_sys) disable iff (!rstn)
    (clr_cmd && !lnk.det_valid) |=> error_n ##1 (error_n || $past(wr_exc) || $past(init_cmd));
  endproperty
  a_error_follows: assert property (p_error_follows) else $error("error line stayed low after clear");

  property p_masked_quiet;
    @(posedge clk_sys) disable iff (!rstn)
    (lnk.det_valid && !lnk.unmasked && error_n) |=> error_n && ((flags & $past(lnk.pick)) == $past(lnk.pick));
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked exception signalled host");

  property p_unmasked_error;
    @(posedge clk_sys) disable iff (!rstn)
    (lnk.det_valid && lnk.unmasked) |=> !error_n && status_word[`FPI_SW_BUSY_BIT];
  endproperty
  a_unmasked_error: assert property (p_unmasked_error) else $error("unmasked exception not signalled");

  c_init: cover property (@(posedge clk_sys) disable iff (!rstn) init_cmd ##1 error_n);
  c_masked: cover property (@(posedge clk_sys) disable iff (!rstn) irq_ev[`FPI_IRQ_MASKED_BIT]);
  c_unmasked: cover property (@(posedge clk_sys) disable iff (!rstn) irq_ev[`FPI_IRQ_ERROR_BIT] ##1 !error_n);
  c_irq: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(irq));
endmodule

// [dv/fpi_host_model.sv]
// host cpu seen from the coprocessor: samples the error line on every
// valid instruction, escape or not, except an escape that traps to emulation, and reports the trap it would take
module fpi_host_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic error_n,
  input wire logic instr_valid,
  input wire logic instr_escape,
  input wire logic [31:0] instr_addr,
  input wire logic monitor_coproc_flag,
  input wire logic software_emulate_flag,
  output logic trap_valid,
  output logic [7:0] trap_vec,
  output logic [31:0] trap_link
);
  timeunit 1ns;
  timeprecision 1ps;

  // emulation wins over the error line: the opcode never reaches the coprocessor
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trap_valid <= 1'b0;
      trap_vec <= 8'h00;
      trap_link <= 32'h0;
    end else begin
      trap_valid <= 1'b0;
      if (instr_valid && instr_escape && !monitor_coproc_flag && software_emulate_flag) begin
        trap_valid <= 1'b1;
        trap_vec <= 8'h07;
        trap_link <= instr_addr;
      end else if (instr_valid && !error_n) begin
        trap_valid <= 1'b1;
        trap_vec <= 8'h10;
        trap_link <= instr_addr;
      end
    end
  end
endmodule

// [dv/tb_top.sv]
`include "fpi_defines.svh"

module tb_top
  import fpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, error_n, irq;
  logic instr_valid = 1'b0;
  logic instr_escape = 1'b0;
  logic monitor_coproc_flag = 1'b1;
  logic software_emulate_flag = 1'b0;
  logic [31:0] instr_addr = 32'h0;
  logic trap_valid;
  logic [7:0] trap_vec;
  logic [31:0] trap_link;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  fpi_word_type q;

  always #5 clk_sys = ~clk_sys;

  fpi_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .error_n(error_n), .irq(irq));

  fpi_host_model i_host (.clk_sys(clk_sys), .rstn(rstn), .error_n(error_n), .instr_valid(instr_valid),
    .instr_escape(instr_escape), .instr_addr(instr_addr), .monitor_coproc_flag(monitor_coproc_flag),
    .software_emulate_flag(software_emulate_flag), .trap_valid(trap_valid), .trap_vec(trap_vec),
    .trap_link(trap_link));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input fpi_word_type seen, input fpi_word_type exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single ahb-lite transfer; waits on hready rather than assuming zero wait states
  task automatic bus(input logic wr, input logic [7:0] a, input fpi_word_type d, output fpi_word_type r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input fpi_word_type d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input fpi_word_type exp);
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // outputs that change at the commit edge are read half a cycle later
  task automatic settle();
    @(negedge clk_sys);
  endtask

  task automatic host_op(input logic coproc_opcode_class, input fpi_word_type a, input logic [7:0] vec, input logic exp_trap);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_escape <= coproc_opcode_class;
    instr_addr <= a;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    settle();
    check(trap_valid, exp_trap);
    if (exp_trap) begin
      check(trap_vec, vec);
      check(trap_link, a);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    // hardware reset state differs from initialize
    rd_chk(`FPI_OFS_CTRL, 32'h033e);
    rd_chk(`FPI_OFS_STATUS, 32'h8081);
    check(error_n, 1'b0);
    host_op(1'b0, 32'h100, 8'h10, 1'b1);
    // control setting that initialize must overwrite; old infinity bit ignores writes
    wr(`FPI_OFS_CTRL, 32'h1c00);
    rd_chk(`FPI_OFS_CTRL, 32'h0c00);
    // condition code and stack fault with no exception; initialize must clear both
    wr(`FPI_OFS_EXC, 32'h0f40);
    rd_chk(`FPI_OFS_STATUS, 32'hc7c1);
    wr(`FPI_OFS_TAG, 32'h1234);
    wr(`FPI_OFS_OPCODE, 32'h5a5);
    wr(`FPI_OFS_IPTR, 32'hcafe0010);
    wr(`FPI_OFS_OPTR, 32'h0bad0020);
    wr(8'h40, 32'h5a5a5a5a);
    wr(8'h5c, 32'ha5a5a5a5);
    wr(`FPI_OFS_IRQ_EN, 32'h7);
    wr(`FPI_OFS_CMD, 32'h1);
    settle();
    check(error_n, 1'b1);
    rd_chk(`FPI_OFS_CTRL, 32'h033f);
    rd_chk(`FPI_OFS_STATUS, 32'h0);
    rd_chk(`FPI_OFS_TAG, 32'hffff);
    rd_chk(`FPI_OFS_OPCODE, 32'h5a5);
    rd_chk(`FPI_OFS_IPTR, 32'hcafe0010);
    rd_chk(`FPI_OFS_OPTR, 32'h0bad0020);
    rd_chk(8'h40, 32'h5a5a5a5a);
    rd_chk(8'h5c, 32'ha5a5a5a5);
    // interrupt raised, masked, cleared
    rd_chk(`FPI_OFS_IRQ_STAT, 32'h4);
    check(irq, 1'b1);
    wr(`FPI_OFS_IRQ_EN, 32'h0);
    settle();
    settle();
    check(irq, 1'b0);
    wr(`FPI_OFS_IRQ_CLR, 32'h7);
    rd_chk(`FPI_OFS_IRQ_STAT, 32'h0);
    wr(`FPI_OFS_IRQ_EN, 32'h7);
    // masked: every tail of the six events keeps only its lowest flag
    for (int i = 0; i < 6; i++) begin
      wr(`FPI_OFS_EXC, (32'h3f << i) & 32'h3f);
      rd_chk(`FPI_OFS_STATUS, 32'h1 << i);
      check(error_n, 1'b1);
      rd_chk(`FPI_OFS_IRQ_STAT, 32'h1);
      check(irq, 1'b1);
      wr(`FPI_OFS_CMD, 32'h2);
      wr(`FPI_OFS_IRQ_CLR, 32'h1);
    end
    // unmasked denormal and zero divide together, with a stack fault
    wr(`FPI_OFS_CTRL, 32'h0300);
    wr(`FPI_OFS_EXC, 32'h46);
    settle();
    check(error_n, 1'b0);
    rd_chk(`FPI_OFS_STATUS, 32'h80c2);
    host_op(1'b1, 32'h200, 8'h10, 1'b1);
    check(error_n, 1'b0);
    rd_chk(`FPI_OFS_IRQ_STAT, 32'h2);
    wr(`FPI_OFS_CMD, 32'h2);
    settle();
    check(error_n, 1'b1);
    rd_chk(`FPI_OFS_STATUS, 32'h0);
    host_op(1'b1, 32'h204, 8'h00, 1'b0);
    // emulation mode; flags stay exclusive
    @(posedge clk_sys);
    monitor_coproc_flag <= 1'b0;
    software_emulate_flag <= 1'b1;
    host_op(1'b1, 32'h300, 8'h07, 1'b1);
    rd_chk(8'h3c, 32'h0);
    check(hresp, 1'b0);
    check(hreadyout, 1'b1);
    // second reset in mid-run
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(`FPI_OFS_CTRL, 32'h033e);
    check(error_n, 1'b0);
    rd_chk(`FPI_OFS_IRQ_EN, 32'h0);
    finish_test();
  end
endmodule
